// File: pkg/osc_ctrl_pkg.sv
/*
 * Shared constants for the low frequency oscillator control block: register byte
 * offsets, field positions, reset values, writable masks, start-up lengths and states.
 * Assumes a 32-bit APB register bus with byte addresses and one aligned word a register.
 */
package osc_ctrl_pkg;

	// Register byte offsets.
	localparam logic [7:0] CRYSTAL_CTRL_OFFSET  = 8'h14;
	localparam logic [7:0] INTERNAL_CTRL_OFFSET = 8'h18;
	localparam logic [7:0] CLOCK_STATUS_OFFSET  = 8'h0C;
	localparam logic [7:0] INT_STATUS_OFFSET    = 8'h30;
	localparam logic [7:0] INT_MASK_OFFSET      = 8'h34;

	// Internal oscillator control fields.
	localparam int TRIM_LSB          = 16;
	localparam int TRIM_MSB          = 22;
	localparam int CONFIG_LOCK_BIT   = 12;
	localparam int STARTUP_LSB       = 8;
	localparam int STARTUP_MSB       = 10;
	localparam int REQUEST_DRIVEN_BIT = 7;
	localparam int KEEP_STANDBY_BIT  = 6;
	localparam int INT_OUT_32K_BIT   = 2;
	localparam int ENABLE_BIT        = 1;

	// Crystal oscillator control fields.
	localparam int AUTO_AMPLITUDE_BIT = 5;
	localparam int XTAL_OUT_32K_BIT   = 3;
	localparam int CRYSTAL_SELECT_BIT = 2;

	// Status and interrupt fields.
	localparam int READY_BIT         = 0;
	localparam int EV_READY_BIT      = 0;
	localparam int EV_LOCK_DROP_BIT  = 1;
	localparam int EVENT_COUNT       = 2;

	// Reset values and writable masks.
	localparam logic [31:0] INTERNAL_CTRL_RESET = 32'h003F_0080;
	localparam logic [31:0] INTERNAL_CTRL_MASK  = 32'h007F_17C6;
	localparam logic [31:0] CRYSTAL_CTRL_RESET  = 32'h0000_0080;
	localparam logic [31:0] CRYSTAL_CTRL_MASK   = 32'h0000_00EE;
	localparam logic [1:0]  INT_MASK_RESET      = 2'h0;

	// Start-up lengths in oscillator cycles for selector codes 0 to 7.
	localparam logic [7:0] STARTUP_LEN_0 = 8'h03;
	localparam logic [7:0] STARTUP_LEN_1 = 8'h04;
	localparam logic [7:0] STARTUP_LEN_2 = 8'h06;
	localparam logic [7:0] STARTUP_LEN_3 = 8'h0A;
	localparam logic [7:0] STARTUP_LEN_4 = 8'h12;
	localparam logic [7:0] STARTUP_LEN_5 = 8'h22;
	localparam logic [7:0] STARTUP_LEN_6 = 8'h42;
	localparam logic [7:0] STARTUP_LEN_7 = 8'h82;

	// Synchronisation delay in oscillator cycles before ready is flagged.
	localparam logic [1:0] READY_SYNC_CYCLES = 2'h2;

	// Start-up sequencer states.
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_COUNT = 2'b01,
		ST_SYNC  = 2'b10,
		ST_READY = 2'b11
	} startup_state_t;

endpackage

// File: hw/startup_counter.sv
/*
 * Start-up sequencer of the internal 32kHz oscillator: counts the selected number of
 * low power oscillator ticks, then two internal oscillator ticks, then flags ready.
 * Assumes both tick inputs are single-cycle pulses already synchronised to clk_i.
 */
`timescale 1ns/1ps

module startup_counter (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic [2:0] select_i,
	input  wire logic       ulp_tick_i,
	input  wire logic       osc_tick_i,
	output logic            ready_o
);

	osc_ctrl_pkg::startup_state_t state;
	osc_ctrl_pkg::startup_state_t next_state;
	logic [7:0]                   count;
	logic [7:0]                   next_count;
	logic [7:0]                   length;

	// Maps a selector code to its start-up length.
	function automatic logic [7:0] startup_length(input logic [2:0] code);
		case (code)
			3'h0:    startup_length = osc_ctrl_pkg::STARTUP_LEN_0;
			3'h1:    startup_length = osc_ctrl_pkg::STARTUP_LEN_1;
			3'h2:    startup_length = osc_ctrl_pkg::STARTUP_LEN_2;
			3'h3:    startup_length = osc_ctrl_pkg::STARTUP_LEN_3;
			3'h4:    startup_length = osc_ctrl_pkg::STARTUP_LEN_4;
			3'h5:    startup_length = osc_ctrl_pkg::STARTUP_LEN_5;
			3'h6:    startup_length = osc_ctrl_pkg::STARTUP_LEN_6;
			default: startup_length = osc_ctrl_pkg::STARTUP_LEN_7;
		endcase
	endfunction

	assign length = startup_length(select_i);

	// Sequencer: the count runs on low power ticks, then the sync delay on osc ticks.
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			osc_ctrl_pkg::ST_OFF: begin
				next_count = 8'h00;
				if (run_i) begin
					next_state = osc_ctrl_pkg::ST_COUNT;
				end
			end
			osc_ctrl_pkg::ST_COUNT: begin
				if (ulp_tick_i) begin
					next_count = count + 8'h01;
					if (count + 8'h01 >= length) begin
						next_state = osc_ctrl_pkg::ST_SYNC;
						next_count = 8'h00;
					end
				end
			end
			osc_ctrl_pkg::ST_SYNC: begin
				if (osc_tick_i) begin
					next_count = count + 8'h01;
					if (count + 8'h01 >= {6'h00, osc_ctrl_pkg::READY_SYNC_CYCLES}) begin
						next_state = osc_ctrl_pkg::ST_READY;
					end
				end
			end
			osc_ctrl_pkg::ST_READY: begin
				next_count = 8'h00;
			end
			default: begin
				next_state = osc_ctrl_pkg::ST_OFF;
				next_count = 8'h00;
			end
		endcase
		// Stopping the oscillator abandons any start-up in progress.
		if (!run_i) begin
			next_state = osc_ctrl_pkg::ST_OFF;
			next_count = 8'h00;
		end
	end

	// State and count registers.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= osc_ctrl_pkg::ST_OFF;
			count <= 8'h00;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Ready is registered from the next state, so it is high exactly while in the final state.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_o <= 1'b0;
		end else begin
			ready_o <= (next_state == osc_ctrl_pkg::ST_READY);
		end
	end

endmodule

// File: hw/low_freq_osc_control.sv
/*
 * Control logic for the internal 32kHz oscillator and the crystal 32kHz oscillator,
 * with an APB register slave, a start-up sequencer and a level interrupt.
 * Assumes the low power and internal oscillator clocks arrive as asynchronous pins,
 * while the request and standby inputs come from logic on clk_i.
 */
`timescale 1ns/1ps

module low_freq_osc_control (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        ulp_osc_clk_i,
	input  wire logic        internal_osc_clk_i,
	input  wire logic        internal_clk_request_i,
	input  wire logic        crystal_clk_request_i,
	input  wire logic        standby_i,
	output logic             internal_osc_run_o,
	output logic [6:0]       trim_value_o,
	output logic             internal_32k_o,
	output logic             internal_32k_ready_o,
	output logic             crystal_osc_run_o,
	output logic             auto_amplitude_enable_o,
	output logic             crystal_32k_out_en_o,
	output logic             crystal_select_o,
	output logic             osc_out_pin_gpio_o,
	output logic             irq_o
);

	logic        rst_sync1;
	logic        rst_n;
	logic [31:0] internal_ctrl;
	logic [31:0] crystal_ctrl;
	logic [1:0]  int_status;
	logic [1:0]  int_mask;
	logic        ulp_sync1;
	logic        ulp_sync2;
	logic        ulp_prev;
	logic        osc_sync1;
	logic        osc_sync2;
	logic        osc_prev;
	logic        ready;
	logic        ready_prev;

	wire         setup_phase;
	wire         access_phase;
	wire         write_access;
	wire         read_access;
	wire         hit_internal;
	wire         hit_crystal;
	wire         hit_status;
	wire         hit_int_status;
	wire         hit_int_mask;
	wire         hit_any;
	wire [31:0]  byte_mask;
	wire         internal_locked;
	wire         write_internal;
	wire         write_crystal;
	wire         lock_drop_event;
	wire         ready_event;
	wire [1:0]   events;
	wire [1:0]   clear_bits;
	wire [1:0]   next_int_status;
	wire [31:0]  read_mux;
	wire         ulp_tick;
	wire         osc_tick;
	wire         internal_run;
	wire         crystal_run;

	// Merges masked write data into a register, leaving undefined bits at zero.
	function automatic logic [31:0] merge_write(
		input logic [31:0] old_value,
		input logic [31:0] new_value,
		input logic [31:0] lanes,
		input logic [31:0] defined
	);
		logic [31:0] take;
		take        = lanes & defined;
		merge_write = ((old_value & ~take) | (new_value & take)) & defined;
	endfunction

	// Decides whether an oscillator runs from enable, request, standby and policy bits.
	function automatic logic osc_should_run(
		input logic enable,
		input logic request_driven,
		input logic keep_in_standby,
		input logic request,
		input logic standby
	);
		osc_should_run = enable
			&& (!standby || keep_in_standby)
			&& (!request_driven || request);
	endfunction

	// Reset release passes two flip-flops so every other register leaves reset together.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync1 <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n     <= rst_sync1;
		end
	end

	// APB decode; the slave answers in the first access cycle with no wait states.
	assign setup_phase    = psel_i && !penable_i;
	assign access_phase   = psel_i && penable_i;
	assign write_access   = access_phase && pwrite_i;
	assign read_access    = access_phase && !pwrite_i;
	assign hit_internal   = (paddr_i == osc_ctrl_pkg::INTERNAL_CTRL_OFFSET);
	assign hit_crystal    = (paddr_i == osc_ctrl_pkg::CRYSTAL_CTRL_OFFSET);
	assign hit_status     = (paddr_i == osc_ctrl_pkg::CLOCK_STATUS_OFFSET);
	assign hit_int_status = (paddr_i == osc_ctrl_pkg::INT_STATUS_OFFSET);
	assign hit_int_mask   = (paddr_i == osc_ctrl_pkg::INT_MASK_OFFSET);
	assign hit_any        = hit_internal || hit_crystal || hit_status
		|| hit_int_status || hit_int_mask;
	assign pready_o       = 1'b1;
	assign pslverr_o      = access_phase && !hit_any;
	assign byte_mask      = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

	// A locked internal register drops writes; the drop is reported as an event.
	assign internal_locked = internal_ctrl[osc_ctrl_pkg::CONFIG_LOCK_BIT];
	assign write_internal  = write_access && hit_internal && !internal_locked;
	assign lock_drop_event = write_access && hit_internal && internal_locked;
	assign write_crystal   = write_access && hit_crystal;

	// Internal oscillator control register.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			internal_ctrl <= osc_ctrl_pkg::INTERNAL_CTRL_RESET;
		end else if (write_internal) begin
			internal_ctrl <= merge_write(internal_ctrl, pwdata_i, byte_mask,
				osc_ctrl_pkg::INTERNAL_CTRL_MASK);
		end
	end

	// Crystal oscillator control register.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			crystal_ctrl <= osc_ctrl_pkg::CRYSTAL_CTRL_RESET;
		end else if (write_crystal) begin
			crystal_ctrl <= merge_write(crystal_ctrl, pwdata_i, byte_mask,
				osc_ctrl_pkg::CRYSTAL_CTRL_MASK);
		end
	end

	// Interrupt mask register; only the low event bits exist.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			int_mask <= osc_ctrl_pkg::INT_MASK_RESET;
		end else if (write_access && hit_int_mask && pstrb_i[0]) begin
			int_mask <= pwdata_i[osc_ctrl_pkg::EVENT_COUNT-1:0];
		end
	end

	// Both oscillator pins are asynchronous and pass two flip-flops before use.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ulp_sync1 <= 1'b0;
			ulp_sync2 <= 1'b0;
			ulp_prev  <= 1'b0;
			osc_sync1 <= 1'b0;
			osc_sync2 <= 1'b0;
			osc_prev  <= 1'b0;
		end else begin
			ulp_sync1 <= ulp_osc_clk_i;
			ulp_sync2 <= ulp_sync1;
			ulp_prev  <= ulp_sync2;
			osc_sync1 <= internal_osc_clk_i;
			osc_sync2 <= osc_sync1;
			osc_prev  <= osc_sync2;
		end
	end

	// Rising edges of the synchronised oscillator clocks become one-cycle ticks.
	assign ulp_tick = ulp_sync2 && !ulp_prev;
	assign osc_tick = osc_sync2 && !osc_prev;

	// Run decisions for both oscillators.
	assign internal_run = osc_should_run(
		internal_ctrl[osc_ctrl_pkg::ENABLE_BIT],
		internal_ctrl[osc_ctrl_pkg::REQUEST_DRIVEN_BIT],
		internal_ctrl[osc_ctrl_pkg::KEEP_STANDBY_BIT],
		internal_clk_request_i,
		standby_i);
	assign crystal_run = osc_should_run(
		crystal_ctrl[osc_ctrl_pkg::ENABLE_BIT],
		crystal_ctrl[osc_ctrl_pkg::REQUEST_DRIVEN_BIT],
		crystal_ctrl[osc_ctrl_pkg::KEEP_STANDBY_BIT],
		crystal_clk_request_i,
		standby_i);

	// Start-up sequencer for the internal oscillator.
	startup_counter u_startup (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n),
		.run_i      (internal_run),
		.select_i   (internal_ctrl[osc_ctrl_pkg::STARTUP_MSB:osc_ctrl_pkg::STARTUP_LSB]),
		.ulp_tick_i (ulp_tick),
		.osc_tick_i (osc_tick),
		.ready_o    (ready)
	);

	// Oscillator and pad control outputs, all registered.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			internal_osc_run_o      <= 1'b0;
			trim_value_o            <= 7'h00;
			crystal_osc_run_o       <= 1'b0;
			auto_amplitude_enable_o <= 1'b0;
			crystal_32k_out_en_o    <= 1'b0;
			crystal_select_o        <= 1'b0;
			osc_out_pin_gpio_o      <= 1'b1;
		end else begin
			internal_osc_run_o      <= internal_run;
			trim_value_o            <= internal_ctrl[osc_ctrl_pkg::TRIM_MSB:osc_ctrl_pkg::TRIM_LSB];
			crystal_osc_run_o       <= crystal_run;
			auto_amplitude_enable_o <= crystal_ctrl[osc_ctrl_pkg::AUTO_AMPLITUDE_BIT];
			crystal_32k_out_en_o    <= crystal_run
				&& crystal_ctrl[osc_ctrl_pkg::XTAL_OUT_32K_BIT];
			crystal_select_o        <= crystal_ctrl[osc_ctrl_pkg::CRYSTAL_SELECT_BIT];
			osc_out_pin_gpio_o      <= !crystal_ctrl[osc_ctrl_pkg::CRYSTAL_SELECT_BIT];
		end
	end

	// The internal 32kHz clock is passed on only when enabled for output and ready.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			internal_32k_o       <= 1'b0;
			internal_32k_ready_o <= 1'b0;
		end else begin
			internal_32k_o       <= osc_sync2 && ready
				&& internal_ctrl[osc_ctrl_pkg::INT_OUT_32K_BIT];
			internal_32k_ready_o <= ready;
		end
	end

	// Events: ready rising and a write dropped by the lock.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ready_prev <= 1'b0;
		end else begin
			ready_prev <= ready;
		end
	end

	assign ready_event = ready && !ready_prev;
	assign events      = {lock_drop_event, ready_event};

	// A status read clears only the bits it reported, so no late event is lost; set wins.
	assign clear_bits      = (read_access && hit_int_status) ? prdata_o[1:0] : 2'h0;
	assign next_int_status = (int_status & ~clear_bits) | events;

	// Sticky interrupt status.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			int_status <= 2'h0;
		end else begin
			int_status <= next_int_status;
		end
	end

	// Interrupt line is high while any unmasked status bit is set.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_int_status & int_mask);
		end
	end

	// Read data selection; unmapped addresses and undefined bits read zero.
	assign read_mux =
		hit_internal   ? internal_ctrl :
		hit_crystal    ? crystal_ctrl :
		hit_status     ? {31'h0000_0000, ready} :
		hit_int_status ? {30'h0000_0000, int_status} :
		hit_int_mask   ? {30'h0000_0000, int_mask} :
		32'h0000_0000;

	// Read data is captured in the setup cycle and stands through the access cycle.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_phase && !pwrite_i) begin
			prdata_o <= read_mux;
		end
	end

endmodule

// File: testbench/low_freq_osc_control_checker.sv
/* Concurrent checks on the oscillator control block: bus answer, start-up, outputs.
   Assumes it is bound into low_freq_osc_control and sees only its ports. */
`timescale 1ns/1ps

module osc_ctrl_checker (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       psel_i,
	input wire logic       penable_i,
	input wire logic       pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic       pready_o,
	input wire logic       pslverr_o,
	input wire logic       internal_osc_run_o,
	input wire logic [6:0] trim_value_o,
	input wire logic       internal_32k_ready_o,
	input wire logic       crystal_osc_run_o,
	input wire logic       auto_amplitude_enable_o,
	input wire logic       crystal_32k_out_en_o,
	input wire logic       crystal_select_o,
	input wire logic       osc_out_pin_gpio_o
);
	logic [2:0] settle_cnt;
	logic       settled;
	logic       acc;
	logic       wr_int;
	logic       wr_xtal;
	logic       mapped;

	// Access phase decodes; the internal reset lag is hidden by settled.
	assign acc     = psel_i & penable_i;
	assign wr_int  = acc & pwrite_i & (paddr_i == osc_ctrl_pkg::INTERNAL_CTRL_OFFSET);
	assign wr_xtal = acc & pwrite_i & (paddr_i == osc_ctrl_pkg::CRYSTAL_CTRL_OFFSET);
	assign mapped  = (paddr_i == osc_ctrl_pkg::INTERNAL_CTRL_OFFSET)
		| (paddr_i == osc_ctrl_pkg::CRYSTAL_CTRL_OFFSET)
		| (paddr_i == osc_ctrl_pkg::CLOCK_STATUS_OFFSET)
		| (paddr_i == osc_ctrl_pkg::INT_STATUS_OFFSET)
		| (paddr_i == osc_ctrl_pkg::INT_MASK_OFFSET);
	assign settled = (settle_cnt == 3'h5);

	// Counts edges after reset release until the registered outputs are valid.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			settle_cnt <= 3'h0;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 3'h1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence no_int_write;
		!wr_int [*3];
	endsequence

	a_bus_no_wait: assert property (pready_o)
		else $error("bus answer not ready");
	a_err_unmapped: assert property (acc |-> pslverr_o == !mapped)
		else $error("error response does not match address map");
	a_ready_after_run: assert property (settled && $rose(internal_32k_ready_o) |->
		$past(internal_osc_run_o, 5)) else $error("ready rose too soon after run");
	a_ready_drops: assert property ($fell(internal_osc_run_o) |->
		##[0:2] !internal_32k_ready_o) else $error("ready kept after stop");
	a_pin_free_gpio: assert property (osc_out_pin_gpio_o == !crystal_select_o)
		else $error("output pin use disagrees with crystal select");
	a_xtal_out_run: assert property (crystal_32k_out_en_o |-> crystal_osc_run_o)
		else $error("crystal output enabled while stopped");
	a_trim_held: assert property ((settled ##0 no_int_write) |=> $stable(trim_value_o))
		else $error("trim changed without a write");
	a_amp_by_write: assert property (settled && $changed(auto_amplitude_enable_o) |->
		$past(wr_xtal) || $past(wr_xtal, 2) || $past(wr_xtal, 3))
		else $error("amplitude control changed without a write");
endmodule

bind low_freq_osc_control osc_ctrl_checker u_checker (.*);

// File: testbench/tb.sv
/* Self-checking bench of the oscillator control block over APB.
   Assumes the package and the checker are compiled first; makes both slow clocks. */
`timescale 1ns/1ps

module tb;
	logic        clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd_q;
	logic [3:0]  pstrb_i = 4'hF;
	logic        pready_o, pslverr_o, err_q, irq_o, internal_32k_o, internal_32k_ready_o;
	logic        ulp_osc_clk_i = 0, internal_osc_clk_i = 0, standby_i = 0, ulp_q = 0;
	logic        internal_clk_request_i = 0, crystal_clk_request_i = 0;
	logic        internal_osc_run_o, crystal_osc_run_o, auto_amplitude_enable_o;
	logic        crystal_32k_out_en_o, crystal_select_o, osc_out_pin_gpio_o;
	logic [6:0]  trim_value_o;
	int          failures = 0, samples_checked = 0, cycles = 0, ulp_rises = 0, div_u = 0, div_o = 0;

	low_freq_osc_control dut (.*);

	// System clock.
	always #2 clk_i = ~clk_i;

	// Slow oscillator clocks from unrelated dividers; a rise is counted one edge late.
	always @(posedge clk_i) begin
		div_u <= (div_u == 4) ? 0 : div_u + 1;
		div_o <= (div_o == 6) ? 0 : div_o + 1;
		ulp_q <= ulp_osc_clk_i;
		if (ulp_osc_clk_i && !ulp_q) ulp_rises <= ulp_rises + 1;
		if (div_u == 4) begin
			ulp_osc_clk_i <= ~ulp_osc_clk_i;
		end
		if (div_o == 6) internal_osc_clk_i <= ~internal_osc_clk_i;
	end

	// Cuts a hang short.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			test_done();
		end
	end

	task automatic test_done();
		if (failures == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// Lets n edges pass, then samples settled outputs.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// One APB transfer; read data and error are taken at the edge that sees pready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rd_q = prdata_o;
		err_q = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic t_reset();
		apb(0, 8'h18, 32'h0);
		chk(rd_q, 32'h003F0080, "internal reset value");
		apb(0, 8'h14, 32'h0);
		chk(rd_q, 32'h00000080, "crystal reset value");
		chk(trim_value_o, 7'h3F, "trim reset");
		chk(osc_out_pin_gpio_o, 1'b1, "pin free at reset");
	endtask

	task automatic t_regs();
		apb(1, 8'h14, 32'hFFFFFFFF);
		apb(0, 8'h14, 32'h0);
		chk(rd_q, 32'h000000EE, "crystal defined bits");
		crystal_clk_request_i <= 1'b1;
		cyc(4);
		chk({auto_amplitude_enable_o, crystal_32k_out_en_o, crystal_select_o, osc_out_pin_gpio_o,
			crystal_osc_run_o}, 5'b11101, "crystal outputs on");
		apb(1, 8'h14, 32'h0);
		cyc(4);
		chk({auto_amplitude_enable_o, crystal_32k_out_en_o, crystal_select_o, osc_out_pin_gpio_o,
			crystal_osc_run_o}, 5'b00010, "crystal outputs off");
		apb(1, 8'h18, 32'hFFFFEFFF);
		apb(0, 8'h18, 32'h0);
		chk(rd_q, 32'h007F07C6, "internal defined bits");
		apb(1, 8'h18, 32'h003F0080);
		apb(0, 8'h40, 32'h0);
		chk(rd_q, 32'h0, "unmapped read");
		chk(err_q, 1'b1, "unmapped error");
	endtask

	task automatic t_startup();
		logic [7:0] lens[8];
		int n, got;
		lens = '{osc_ctrl_pkg::STARTUP_LEN_0, osc_ctrl_pkg::STARTUP_LEN_1,
			osc_ctrl_pkg::STARTUP_LEN_2, osc_ctrl_pkg::STARTUP_LEN_3,
			osc_ctrl_pkg::STARTUP_LEN_4, osc_ctrl_pkg::STARTUP_LEN_5,
			osc_ctrl_pkg::STARTUP_LEN_6, osc_ctrl_pkg::STARTUP_LEN_7};
		apb(1, 8'h34, 32'h1);
		apb(0, 8'h30, 32'h0);
		for (int s = 0; s < 8; s++) begin
			apb(1, 8'h18, 32'h003F0002 | (s << 8));
			got = ulp_rises;
			n = 0;
			while (internal_32k_ready_o !== 1'b1 && n < 3000) begin
				n++;
				cyc(1);
			end
			got = ulp_rises - got;
			chk(got >= lens[s] && got <= lens[s] + 4, 1'b1, "start-up length");
			chk(irq_o, 1'b1, "ready interrupt");
			apb(0, 8'h0C, 32'h0);
			chk(rd_q, 32'h1, "ready status");
			apb(0, 8'h30, 32'h0);
			chk(rd_q, 32'h1, "ready event");
			cyc(2);
			chk(irq_o, 1'b0, "interrupt cleared");
			apb(1, 8'h18, 32'h003F0000);
			cyc(4);
			chk(internal_32k_ready_o, 1'b0, "ready after disable");
		end
	endtask

	task automatic t_gating();
		logic [7:0] cfg[7];
		logic [2:0] v[7];
		cfg = '{8'h82, 8'h82, 8'h82, 8'hC2, 8'hC2, 8'h42, 8'h02};
		v = '{3'b000, 3'b101, 3'b110, 3'b111, 3'b010, 3'b011, 3'b001};
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			internal_clk_request_i <= v[i][2];
			standby_i <= v[i][1];
			apb(1, 8'h18, 32'h003F0000 | cfg[i]);
			cyc(4);
			chk(internal_osc_run_o, v[i][0], "run gating");
		end
		@(posedge clk_i);
		standby_i <= 1'b0;
		apb(1, 8'h18, 32'h003F0006);
		cyc(200);
		got_high(60, 1'b1);
		apb(1, 8'h18, 32'h003F0002);
		cyc(3);
		got_high(60, 1'b0);
	endtask

	// Watches the internal 32k output for n cycles and compares whether it was ever high.
	task automatic got_high(input int n, input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			cyc(1);
			seen |= (internal_32k_o === 1'b1);
		end
		chk(seen, exp, "internal 32k output");
	endtask

	task automatic t_lock();
		apb(1, 8'h34, 32'h0);
		apb(0, 8'h30, 32'h0);
		apb(1, 8'h18, 32'h00551002);
		apb(1, 8'h18, 32'h0);
		apb(0, 8'h18, 32'h0);
		chk(rd_q, 32'h00551002, "locked register");
		chk(trim_value_o, 7'h55, "trim output");
		chk(irq_o, 1'b0, "masked event");
		apb(1, 8'h34, 32'h2);
		cyc(2);
		chk(irq_o, 1'b1, "unmasked event");
		apb(0, 8'h30, 32'h0);
		chk(rd_q & 32'h2, 32'h2, "dropped write event");
		cyc(2);
		chk(irq_o, 1'b0, "event cleared");
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_reset();
		t_regs();
		t_startup();
		t_gating();
		t_lock();
		test_done();
	end
endmodule
